// *** rtl/lfb_regs.vh ***
`ifndef LFB_REGS_VH
`define LFB_REGS_VH

// Register indices; byte address on APB is four times the index
`define LFB_IDX_SHIFT_WIDTHS 30'h0a00_0416
`define LFB_IDX_FB_START_LOW 30'h0a00_0418
`define LFB_IDX_FB_START_HIGH 30'h0a00_041a
`define LFB_IDX_FB_END_LOW 30'h0a00_0420
`define LFB_IDX_FB_END_HIGH 30'h0a00_0422
`define LFB_IDX_MARKER_FIRST 30'h0a00_0424
`define LFB_IDX_MARKER_SECOND 30'h0a00_0426
`define LFB_IDX_CORE_CTRL 30'h0a00_0428
`define LFB_IDX_CORE_STATUS 30'h0a00_042a
`define LFB_IDX_FETCH_LOW 30'h0a00_042c
`define LFB_IDX_FETCH_HIGH 30'h0a00_042e

// Field positions
`define LFB_LOW_CYC_MSB 13
`define LFB_LOW_CYC_LSB 8
`define LFB_HIGH_CYC_MSB 5
`define LFB_HIGH_CYC_LSB 0
`define LFB_ADDR_HIGH_MSB 12
`define LFB_MARKER_MSB 7
`define LFB_CTRL_PRESCALE_MSB 1
`define LFB_CTRL_PRESCALE_LSB 0
`define LFB_CTRL_ENABLE_BIT 2

// Prescaler codes
`define LFB_PRESCALE_DIV1 2'b00
`define LFB_PRESCALE_DIV2 2'b01
`define LFB_PRESCALE_DIV4 2'b10
`define LFB_PRESCALE_RSVD 2'b11

// Reset values
`define LFB_RESET_HALF 16'h0000
`define LFB_RESET_CTRL 2'h0

// Fetch word step in bytes
`define LFB_FETCH_STEP 32'h0000_0004

`endif

// *** rtl/lfb_prescaler.v ***
`timescale 1ns/1ps
`include "lfb_regs.vh"

module lfb_prescaler
(
   input wire pclk,
   input wire presetn,
   input wire run,
   input wire [1:0] prescale,
   output reg core_tick
);

reg [1:0] div_cnt_reg;
reg [1:0] div_cnt_next;
reg tick_next;

always @*
begin
   div_cnt_next = div_cnt_reg + 2'd1;
   tick_next = 1'b0;
   case (prescale)
      `LFB_PRESCALE_DIV1:
      begin
         tick_next = run;
         div_cnt_next = 2'd0;
      end
      `LFB_PRESCALE_DIV2:
         tick_next = run & div_cnt_reg[0];
      `LFB_PRESCALE_DIV4:
         tick_next = run & (div_cnt_reg == 2'd3);
      default:
      begin
         // Reserved code stops the core rather than guess a rate
         tick_next = 1'b0;
         div_cnt_next = 2'd0;
      end
   endcase
   if (!run)
   begin
      div_cnt_next = 2'd0;
   end
end

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      div_cnt_reg <= 2'd0;
      core_tick <= 1'b0;
   end
   else
   begin
      div_cnt_reg <= div_cnt_next;
      core_tick <= tick_next;
   end
end

endmodule // lfb_prescaler

// *** rtl/lfb_timing.v ***
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "lfb_regs.vh"

module lfb_timing
#(
   parameter LINE_PIXELS = 320,
   parameter FRAME_LINES = 240,
   parameter XW = 10,
   parameter YW = 10
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   output reg shift_clk,
   output reg frame_marker,
   output reg frame_start,
   output reg fetch_valid,
   output reg [31:0] fetch_addr,
   input wire fetch_ready
);

reg [5:0] shift_low_cycles_reg;
reg [5:0] shift_high_cycles_reg;
reg [15:0] start_low_reg;
reg [12:0] start_high_reg;
reg [15:0] end_low_reg;
reg [12:0] end_high_reg;
reg [7:0] marker_first_edge_x_reg;
reg [7:0] marker_second_edge_x_reg;
reg [1:0] prescale_reg;
reg core_enable_reg;

// Shadow copies used by the running frame
reg [5:0] low_sh_reg;
reg [5:0] high_sh_reg;
reg [31:0] buffer_start_address_reg;
reg [31:0] buffer_end_address_reg;
reg [7:0] first_sh_reg;
reg [7:0] second_sh_reg;

reg [5:0] phase_cnt_reg;
reg [XW-1:0] x_reg;
reg [YW-1:0] y_reg;
reg active_reg;

wire core_tick;
wire setup_phase;
wire access_write;
wire [29:0] word_idx;
wire addr_hit;
wire [5:0] low_len;
wire [5:0] high_len;
wire phase_done;
wire line_done;
wire frame_done;
wire load_shadow;
wire [XW-1:0] edge_first;
wire [XW-1:0] edge_second;
reg [15:0] read_mux;

// Zero width would stall the clock; treat it as one cycle
function [5:0] lfb_len;
   input [5:0] val;
   begin
      lfb_len = (val == 6'd0) ? 6'd1 : val;
   end
endfunction

// Doubled 8-bit edge value widened to pixel counter width
function [XW-1:0] lfb_edge;
   input [7:0] half;
   begin
      lfb_edge = {{(XW-9){1'b0}}, half, 1'b0};
   end
endfunction

// Halfword write with byte lanes
function [15:0] lfb_merge;
   input [15:0] old;
   input [15:0] wd;
   input [1:0] strb;
   begin
      lfb_merge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
   end
endfunction

lfb_prescaler u_prescaler
(
   .pclk(pclk),
   .presetn(presetn),
   .run(core_enable_reg),
   .prescale(prescale_reg),
   .core_tick(core_tick)
);

// APB slave: zero wait states, read data captured in setup phase
assign word_idx = paddr[31:2];
assign addr_hit = (word_idx == `LFB_IDX_SHIFT_WIDTHS) ||
                  (word_idx == `LFB_IDX_FB_START_LOW) ||
                  (word_idx == `LFB_IDX_FB_START_HIGH) ||
                  (word_idx == `LFB_IDX_FB_END_LOW) ||
                  (word_idx == `LFB_IDX_FB_END_HIGH) ||
                  (word_idx == `LFB_IDX_MARKER_FIRST) ||
                  (word_idx == `LFB_IDX_MARKER_SECOND) ||
                  (word_idx == `LFB_IDX_CORE_CTRL) ||
                  (word_idx == `LFB_IDX_CORE_STATUS) ||
                  (word_idx == `LFB_IDX_FETCH_LOW) ||
                  (word_idx == `LFB_IDX_FETCH_HIGH);
assign pready = 1'b1;
assign pslverr = psel & penable & ~addr_hit;
assign setup_phase = psel & ~penable;
assign access_write = psel & penable & pwrite & addr_hit;

always @*
begin
   read_mux = 16'h0000;
   case (word_idx)
      `LFB_IDX_SHIFT_WIDTHS:
         read_mux = {2'b00, shift_low_cycles_reg, 2'b00, shift_high_cycles_reg};
      `LFB_IDX_FB_START_LOW:
         read_mux = start_low_reg;
      `LFB_IDX_FB_START_HIGH:
         read_mux = {3'b000, start_high_reg};
      `LFB_IDX_FB_END_LOW:
         read_mux = end_low_reg;
      `LFB_IDX_FB_END_HIGH:
         read_mux = {3'b000, end_high_reg};
      `LFB_IDX_MARKER_FIRST:
         read_mux = {8'h00, marker_first_edge_x_reg};
      `LFB_IDX_MARKER_SECOND:
         read_mux = {8'h00, marker_second_edge_x_reg};
      `LFB_IDX_CORE_CTRL:
         read_mux = {13'h0000, core_enable_reg, prescale_reg};
      `LFB_IDX_CORE_STATUS:
         read_mux = {13'h0000, fetch_valid, frame_marker, active_reg};
      `LFB_IDX_FETCH_LOW:
         read_mux = fetch_addr[15:0];
      `LFB_IDX_FETCH_HIGH:
         read_mux = fetch_addr[31:16];
      default:
         read_mux = 16'h0000;
   endcase
end

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      prdata <= 32'h0000_0000;
   end
   else if (setup_phase)
   begin
      prdata <= {16'h0000, read_mux};
   end
end

// Register writes; all fields reset to zero
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      shift_low_cycles_reg <= 6'd0;
      shift_high_cycles_reg <= 6'd0;
      start_low_reg <= `LFB_RESET_HALF;
      start_high_reg <= 13'h0000;
      end_low_reg <= `LFB_RESET_HALF;
      end_high_reg <= 13'h0000;
      marker_first_edge_x_reg <= 8'h00;
      marker_second_edge_x_reg <= 8'h00;
      prescale_reg <= `LFB_RESET_CTRL;
      core_enable_reg <= 1'b0;
   end
   else if (access_write)
   begin
      case (word_idx)
         `LFB_IDX_SHIFT_WIDTHS:
         begin
            if (pstrb[1])
               shift_low_cycles_reg <= pwdata[`LFB_LOW_CYC_MSB:`LFB_LOW_CYC_LSB];
            if (pstrb[0])
               shift_high_cycles_reg <= pwdata[`LFB_HIGH_CYC_MSB:`LFB_HIGH_CYC_LSB];
         end
         `LFB_IDX_FB_START_LOW:
            start_low_reg <= lfb_merge(start_low_reg, pwdata[15:0], pstrb[1:0]);
         `LFB_IDX_FB_START_HIGH:
            start_high_reg <= {pstrb[1] ? pwdata[12:8] : start_high_reg[12:8],
                               pstrb[0] ? pwdata[7:0] : start_high_reg[7:0]};
         `LFB_IDX_FB_END_LOW:
            end_low_reg <= lfb_merge(end_low_reg, pwdata[15:0], pstrb[1:0]);
         `LFB_IDX_FB_END_HIGH:
         begin
            if (pstrb[1])
               end_high_reg[12:8] <= pwdata[12:8];
            if (pstrb[0])
               end_high_reg[7:0] <= pwdata[7:0];
         end
         `LFB_IDX_MARKER_FIRST:
            if (pstrb[0])
               marker_first_edge_x_reg <= pwdata[`LFB_MARKER_MSB:0];
         `LFB_IDX_MARKER_SECOND:
            if (pstrb[0])
               marker_second_edge_x_reg <= pwdata[`LFB_MARKER_MSB:0];
         `LFB_IDX_CORE_CTRL:
            if (pstrb[0])
            begin
               prescale_reg <= pwdata[`LFB_CTRL_PRESCALE_MSB:`LFB_CTRL_PRESCALE_LSB];
               core_enable_reg <= pwdata[`LFB_CTRL_ENABLE_BIT];
            end
         default:
            core_enable_reg <= core_enable_reg;
      endcase
   end
end

// Shift clock, pixel and line counters, all on core enable pulses
assign low_len = lfb_len(low_sh_reg);
assign high_len = lfb_len(high_sh_reg);
assign phase_done = core_tick & (phase_cnt_reg == ((shift_clk ? high_len : low_len) - 6'd1));
assign line_done = phase_done & shift_clk & (x_reg == LINE_PIXELS[XW-1:0] - 1'b1);
assign frame_done = line_done & (y_reg == FRAME_LINES[YW-1:0] - 1'b1);
// Idle core keeps shadows tracking so enabling starts from fresh values
assign load_shadow = ~active_reg | frame_done;

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      phase_cnt_reg <= 6'd0;
      shift_clk <= 1'b0;
      x_reg <= {XW{1'b0}};
      y_reg <= {YW{1'b0}};
      active_reg <= 1'b0;
      frame_start <= 1'b0;
   end
   else if (!core_enable_reg)
   begin
      phase_cnt_reg <= 6'd0;
      shift_clk <= 1'b0;
      x_reg <= {XW{1'b0}};
      y_reg <= {YW{1'b0}};
      active_reg <= 1'b0;
      frame_start <= 1'b0;
   end
   else
   begin
      frame_start <= (~active_reg & core_tick) | frame_done;
      active_reg <= active_reg | core_tick;
      if (phase_done)
      begin
         phase_cnt_reg <= 6'd0;
         shift_clk <= ~shift_clk;
         if (shift_clk)
         begin
            if (x_reg == LINE_PIXELS[XW-1:0] - 1'b1)
            begin
               x_reg <= {XW{1'b0}};
               y_reg <= (y_reg == FRAME_LINES[YW-1:0] - 1'b1) ? {YW{1'b0}} : y_reg + 1'b1;
            end
            else
            begin
               x_reg <= x_reg + 1'b1;
            end
         end
      end
      else if (core_tick)
      begin
         phase_cnt_reg <= phase_cnt_reg + 6'd1;
      end
   end
end

// Shadow registers for the frame in progress
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      low_sh_reg <= 6'd0;
      high_sh_reg <= 6'd0;
      buffer_start_address_reg <= 32'h0000_0000;
      buffer_end_address_reg <= 32'h0000_0000;
      first_sh_reg <= 8'h00;
      second_sh_reg <= 8'h00;
   end
   else if (load_shadow)
   begin
      low_sh_reg <= shift_low_cycles_reg;
      high_sh_reg <= shift_high_cycles_reg;
      buffer_start_address_reg <= {3'b000, start_high_reg, start_low_reg};
      buffer_end_address_reg <= {3'b000, end_high_reg, end_low_reg};
      first_sh_reg <= marker_first_edge_x_reg;
      second_sh_reg <= marker_second_edge_x_reg;
   end
end

// Frame marker spans the first line between the doubled edges
assign edge_first = lfb_edge(first_sh_reg);
assign edge_second = lfb_edge(second_sh_reg);

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      frame_marker <= 1'b0;
   end
   else
   begin
      frame_marker <= active_reg & (y_reg == {YW{1'b0}}) &
                      (x_reg >= edge_first) & (x_reg < edge_second);
   end
end

// Sequential word fetch; the packed buffer needs only address increments
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      fetch_valid <= 1'b0;
      fetch_addr <= 32'h0000_0000;
   end
   else if (!core_enable_reg)
   begin
      fetch_valid <= 1'b0;
   end
   else if ((~active_reg & core_tick) | frame_done)
   begin
      fetch_valid <= 1'b1;
      // Restart from the start of the buffer on every frame
      fetch_addr <= load_shadow & active_reg ?
                    {3'b000, start_high_reg, start_low_reg} :
                    buffer_start_address_reg;
   end
   else if (fetch_valid & fetch_ready)
   begin
      if (fetch_addr >= buffer_end_address_reg)
      begin
         fetch_valid <= 1'b0;
      end
      else
      begin
         fetch_addr <= fetch_addr + `LFB_FETCH_STEP;
      end
   end
end

endmodule // lfb_timing

// *** test/lfb_timing_sva.sv ***
`timescale 1ns/1ps
`include "lfb_regs.vh"
module lfb_timing_sva
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire shift_clk,
   input wire frame_marker,
   input wire frame_start,
   input wire fetch_valid,
   input wire [31:0] fetch_addr,
   input wire fetch_ready
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire rd = psel && penable && !pwrite;
   wire [29:0] ix = paddr[31:2];
   upper_zero_a: assert property (rd |-> prdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   widths_rsvd_a: assert property (rd && ix == `LFB_IDX_SHIFT_WIDTHS
      |-> prdata[15:14] == 2'b00 && prdata[7:6] == 2'b00) else $error("width spare bits");
   start_top_a: assert property (rd && ix == `LFB_IDX_FB_START_HIGH |-> prdata[15:13] == 3'b000)
      else $error("start top bits set");
   end_top_a: assert property (rd && ix == `LFB_IDX_FB_END_HIGH |-> prdata[15:13] == 3'b000)
      else $error("end top bits set");
   marker_rsvd_a: assert property (rd && (ix == `LFB_IDX_MARKER_FIRST
      || ix == `LFB_IDX_MARKER_SECOND) |-> prdata[15:8] == 8'h00) else $error("marker spare");
   fetch_hold_a: assert property (fetch_valid && !fetch_ready |=> fetch_valid && $stable(fetch_addr))
      else $error("fetch request dropped");
   fetch_step_a: assert property ((fetch_valid && fetch_ready) ##1 (fetch_valid && !frame_start)
      |-> fetch_addr == $past(fetch_addr) + 32'h0000_0004) else $error("fetch step wrong");
   frame_fetch_a: assert property (frame_start |-> ##[0:2] fetch_valid)
      else $error("no fetch at frame start");
   c_frame: cover property (frame_start);
   c_stall: cover property (fetch_valid && !fetch_ready);
   c_err: cover property (pslverr);
endmodule // lfb_timing_sva
bind lfb_timing lfb_timing_sva i_lfb_timing_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .shift_clk(shift_clk),
   .frame_marker(frame_marker), .frame_start(frame_start), .fetch_valid(fetch_valid),
   .fetch_addr(fetch_addr), .fetch_ready(fetch_ready));

// *** test/lfb_mem_model.sv ***
`timescale 1ns/1ps
module lfb_mem_model
(
   input wire pclk,
   input wire presetn,
   input wire slow,
   input wire clr,
   input wire fetch_valid,
   input wire [31:0] fetch_addr,
   output wire fetch_ready
);
   logic [31:0] got [0:7];
   int n_got;
   logic [1:0] ph;
   // Slow mode is ready one cycle in four, so requests must wait
   assign fetch_ready = !slow || ph == 2'b00;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ph <= 2'b00;
         n_got <= 0;
      end
      else
      begin
         ph <= ph + 2'b01;
         if (clr)
            n_got <= 0;
         else if (fetch_valid && fetch_ready)
         begin
            if (n_got < 8)
               got[n_got] <= fetch_addr;
            n_got <= n_got + 1;
         end
      end
   end
endmodule // lfb_mem_model

// *** test/lfb_timing_test.sv ***
`timescale 1ns/1ps
`include "lfb_regs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %0t mismatch got %h exp %h", $time, g, e); end end
module lfb_timing_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, clr = 0, err, hold;
   logic [31:0] paddr = 0, pwdata = 0, rd;
   logic [3:0] pstrb = 4'hf;
   wire [31:0] prdata, fetch_addr;
   wire pready, pslverr, shift_clk, frame_marker, frame_start, fetch_valid, fetch_ready;
   int n_fail = 0, compares = 0, n, dv;
   logic [29:0] ix [0:6] = '{`LFB_IDX_SHIFT_WIDTHS, `LFB_IDX_FB_START_LOW,
      `LFB_IDX_FB_START_HIGH, `LFB_IDX_FB_END_LOW, `LFB_IDX_FB_END_HIGH,
      `LFB_IDX_MARKER_FIRST, `LFB_IDX_MARKER_SECOND};
   logic [31:0] ex [0:6] = '{32'h0000_3f3f, 32'h0000_fff8, 32'h0000_1fff, 32'h0000_ffff,
      32'h0000_1fff, 32'h0000_00ff, 32'h0000_00ff};
   always #25 pclk = ~pclk;
   lfb_timing #(.LINE_PIXELS(8), .FRAME_LINES(4)) i_lfb_timing (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .shift_clk(shift_clk),
      .frame_marker(frame_marker), .frame_start(frame_start), .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr), .fetch_ready(fetch_ready));
   lfb_mem_model i_lfb_mem_model (.pclk(pclk), .presetn(presetn), .slow(slow), .clr(clr),
      .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .fetch_ready(fetch_ready));
   task close_out;
      if (n_fail == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task apb(input logic wr, input logic [29:0] a, input logic [31:0] wd);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {a, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 16);
      if (pready !== 1'b1)
      begin
         n_fail++;
         close_out;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   function logic pick(int s);
      return s == 0 ? shift_clk : s == 1 ? frame_marker : s == 2 ? frame_start : !shift_clk;
   endfunction
   // Counts high cycles of the chosen line, waiting for a fresh rise first
   task meas(input int s);
      int i;
      i = 0;
      while (pick(s) !== 1'b0 && i < 4000) begin @(posedge pclk); i++; end
      while (pick(s) !== 1'b1 && i < 4000) begin @(posedge pclk); i++; end
      n = 0;
      while (pick(s) === 1'b1 && i < 4000) begin @(posedge pclk); n++; i++; end
      if (i >= 4000)
      begin
         n_fail++;
         close_out;
      end
   endtask
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int k = 0; k < 7; k++)
      begin
         apb(0, ix[k], 0);
         `CHK(rd, 32'h0000_0000)
         apb(1, ix[k], k == 1 ? 32'h0000_fff8 : 32'h0000_ffff);
         apb(0, ix[k], 0);
         `CHK(rd, ex[k])
      end
      apb(0, 30'h0a00_0400, 0);
      `CHK({err, rd}, 33'h0_0000_0000 | 33'h1_0000_0000)
      apb(1, `LFB_IDX_SHIFT_WIDTHS, 32'h0000_0302);
      apb(1, `LFB_IDX_FB_START_LOW, 32'h0000_1000);
      apb(1, `LFB_IDX_FB_START_HIGH, 0);
      apb(1, `LFB_IDX_FB_END_LOW, 32'h0000_1010);
      apb(1, `LFB_IDX_FB_END_HIGH, 0);
      apb(1, `LFB_IDX_MARKER_FIRST, 32'h0000_0001);
      apb(1, `LFB_IDX_MARKER_SECOND, 32'h0000_0002);
      for (int c = 0; c < 3; c++)
      begin
         dv = 1 << c;
         apb(1, `LFB_IDX_CORE_CTRL, 32'h0000_0004 | c);
         meas(2);
         `CHK(n, 1)
         if (c == 0)
         begin
            // Let the first words of the frame reach the memory model
            repeat (4) @(posedge pclk);
            for (int k = 0; k < 4; k++)
               `CHK(i_lfb_mem_model.got[k], 32'h0000_1000 + 4 * k)
            meas(1);
            `CHK(n, 10)
         end
         meas(0);
         `CHK(n, 2 * dv)
         meas(3);
         `CHK(n, 3 * dv)
      end
      slow <= 1'b1;
      apb(1, `LFB_IDX_FB_START_LOW, 32'h0000_2000);
      apb(1, `LFB_IDX_FB_END_LOW, 32'h0000_2010);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      meas(2);
      meas(2);
      // Slow memory needs up to four cycles per word
      repeat (6) @(posedge pclk);
      for (int k = 0; k < 6; k++)
         `CHK(i_lfb_mem_model.got[k], 32'h0000_2000 + 4 * (k % 5))
      apb(0, `LFB_IDX_CORE_CTRL, 0);
      `CHK(rd, 32'h0000_0006)
      apb(1, `LFB_IDX_CORE_CTRL, 32'h0000_0007);
      // A tick already in flight may still move the clock once
      repeat (2) @(posedge pclk);
      hold = shift_clk;
      repeat (40) @(posedge pclk);
      `CHK(shift_clk, hold)
      close_out;
   end
endmodule // lfb_timing_test
